// File: inc/mchc_defines.vh
// How it works
// - Six-bit gate pattern changes only by shadow transfer from gate shadow field, by a write with transfer request, or by idle forcing it to zero.
// - Pattern bits 0..5 gate compare/complement outputs of channels 0, 1, 2.
// - Pattern gates outputs only while multichannel enable is set.
// - Pattern bit 0 with mode enabled forces output passive.
// - Pattern bit 1 passes the selected timer PWM.
// - Pending flag bit 6 sets on selected trigger, holds until sync transfer.
// - Pending flag clears on transfer and stays clear while enable is 0.
// - Idle control forces the gate pattern to zero.
// - Expected sensor pattern loaded by transfer, compared after each sensor edge.
// - Match with expected sets correct event; interrupt only when enabled.
// - Match with neither pattern sets wrong event; interrupt only when enabled.
// - Match with present pattern is a spike; no event flagged.
// - Present sensor pattern in bits 5:3, loaded by transfer, used in compare.
// - Pattern bits 2,1,0 map to sensor inputs 2,1,0.
// - Reserved status bits read zero.
// - Write with transfer request copies new shadow at once; request reads 0.
// - Sensor shadows move into active patterns on a sensor edge.
// - Sync select 00 direct, 01 T13 zero, 10 T12 zero up, 11 none.
// - Trigger select chooses which event sets the pending flag.
`ifndef MCHC_DEFINES_VH
`define MCHC_DEFINES_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define MCHC_A_STAT_LO 4'h0
`define MCHC_A_STAT_HI 4'h1
`define MCHC_A_GATE_SH 4'h2
`define MCHC_A_SENS_SH 4'h3
`define MCHC_A_CTRL 4'h4
`define MCHC_A_MODE 4'h5
`define MCHC_A_EVENT 4'h6
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCHC_REQ_BIT 7
`define MCHC_PEND_BIT 6
`define MCHC_SYNC_LO 4
`define MCHC_MODE_EN_BIT 0
`define MCHC_MODE_IDLE_BIT 1
`define MCHC_MODE_CEN_BIT 2
`define MCHC_MODE_WEN_BIT 3
`define MCHC_EV_CLR_C 0
`define MCHC_EV_CLR_W 1
// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define MCHC_SYN_DIRECT 2'h0
`define MCHC_SYN_T13Z 2'h1
`define MCHC_SYN_T12Z 2'h2
`define MCHC_SEL_CORR 3'h1
`define MCHC_SEL_T13P 3'h2
`define MCHC_SEL_T12O 3'h3
`define MCHC_SEL_T12C1 3'h4
`define MCHC_SEL_T12P 3'h5
`define MCHC_RST_BYTE 8'h00
`endif

// File: src/mchc_sync.v
`timescale 1ns/10ps
// ----------------------------------------
// Three-stage sensor input synchroniser
// ----------------------------------------
module mchc_sync (
	// Clock and reset
	input wire mclk_i,
	input wire rst_i,
	// Pins and filtered level
	input wire [2:0] pin_i,
	output reg [2:0] level_o
);
	reg [2:0] s1_q;
	reg [2:0] s2_q;
	reg [2:0] s3_q;
	genvar g;
	always @(posedge mclk_i) begin
		if (rst_i) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// Level moves only once stages two and three agree
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_bit
			always @(posedge mclk_i) begin
				if (rst_i)
					level_o[g] <= 1'b0;
				else if (s2_q[g] == s3_q[g])
					level_o[g] <= s3_q[g];
			end
		end
	endgenerate
endmodule // mchc_sync

// File: src/mchc_top.v
`timescale 1ns/10ps
`include "mchc_defines.vh"
module mchc_top (
	// Clock and reset
	input wire mclk_i,
	input wire rst_i,
	// Register port
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// Hall sensor pins
	input wire [2:0] sensor_input_i,
	// Timer PWM, already chosen per output by modulation control
	input wire [5:0] pwm_i,
	// Passive levels of the six outputs
	input wire [5:0] passive_i,
	// Timer events
	input wire t13_period_i,
	input wire t13_zero_i,
	input wire t12_one_down_i,
	input wire t12_ch1_match_i,
	input wire t12_period_up_i,
	input wire t12_zero_up_i,
	// Power stage outputs
	output reg [5:0] out_o,
	// Event requests
	output wire correct_irq_o,
	output wire wrong_irq_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [5:0] gate_q;
	reg [5:0] gate_sh_q;
	reg pend_q;
	reg [2:0] exp_q;
	reg [2:0] cur_q;
	reg [2:0] exp_sh_q;
	reg [2:0] cur_sh_q;
	reg [2:0] trig_sel_q;
	reg [1:0] sync_sel_q;
	reg mc_en_q;
	reg idle_q;
	reg cen_q;
	reg wen_q;
	reg corr_q;
	reg wrong_q;
	reg [2:0] prev_q;
	reg corr_pulse_q;
	wire [2:0] hall;
	wire hall_edge;
	wire corr_hit;
	wire wrong_hit;
	reg trig;
	reg sync;
	wire xfer;
	wire wr_gate;
	wire wr_sens;
	wire sw_gate;
	wire sw_sens;
	wire wr_ctrl;
	wire wr_mode;
	wire wr_event;
	wire clr_corr;
	wire clr_wrong;
	reg [5:0] gate_d;
	reg pend_d;
	reg [2:0] exp_d;
	reg [2:0] cur_d;
	reg corr_d;
	reg wrong_d;
	reg [7:0] rdata_d;
	// ----------------------------------------
	// Sensor sampling and edge detect
	// ----------------------------------------
	mchc_sync u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.pin_i(sensor_input_i),
		.level_o(hall)
	);
	always @(posedge mclk_i) begin
		if (rst_i)
			prev_q <= 3'h0;
		else
			prev_q <= hall;
	end
	assign hall_edge = (hall != prev_q);
	// Bit order of hall matches both stored patterns directly
	assign corr_hit = hall_edge && (hall == exp_q);
	// Spike: still at present pattern, neither flag
	assign wrong_hit = hall_edge && (hall != exp_q) && (hall != cur_q);
	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	assign wr_gate = wr_i && (addr_i == `MCHC_A_GATE_SH);
	assign wr_sens = wr_i && (addr_i == `MCHC_A_SENS_SH);
	assign wr_ctrl = wr_i && (addr_i == `MCHC_A_CTRL);
	assign wr_mode = wr_i && (addr_i == `MCHC_A_MODE);
	assign wr_event = wr_i && (addr_i == `MCHC_A_EVENT);
	assign clr_corr = wr_event && wdata_i[`MCHC_EV_CLR_C];
	assign clr_wrong = wr_event && wdata_i[`MCHC_EV_CLR_W];
	assign sw_gate = wr_gate && wdata_i[`MCHC_REQ_BIT];
	assign sw_sens = wr_sens && wdata_i[`MCHC_REQ_BIT];
	// ----------------------------------------
	// Shadow registers
	// ----------------------------------------
	// Shadows never reach the outputs on their own
	always @(posedge mclk_i) begin
		if (rst_i)
			gate_sh_q <= 6'h00;
		else if (wr_gate)
			gate_sh_q <= wdata_i[5:0];
	end
	always @(posedge mclk_i) begin
		if (rst_i) begin
			exp_sh_q <= 3'h0;
			cur_sh_q <= 3'h0;
		end else if (wr_sens) begin
			exp_sh_q <= wdata_i[2:0];
			cur_sh_q <= wdata_i[5:3];
		end
	end
	// ----------------------------------------
	// Control and mode registers
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (rst_i) begin
			trig_sel_q <= 3'h0;
			sync_sel_q <= 2'h0;
		end else if (wr_ctrl) begin
			trig_sel_q <= wdata_i[2:0];
			sync_sel_q <= wdata_i[`MCHC_SYNC_LO+1:`MCHC_SYNC_LO];
		end
	end
	always @(posedge mclk_i) begin
		if (rst_i) begin
			mc_en_q <= 1'b0;
			idle_q <= 1'b0;
			cen_q <= 1'b0;
			wen_q <= 1'b0;
		end else if (wr_mode) begin
			mc_en_q <= wdata_i[`MCHC_MODE_EN_BIT];
			idle_q <= wdata_i[`MCHC_MODE_IDLE_BIT];
			cen_q <= wdata_i[`MCHC_MODE_CEN_BIT];
			wen_q <= wdata_i[`MCHC_MODE_WEN_BIT];
		end
	end
	// ----------------------------------------
	// Trigger and synchronisation select
	// ----------------------------------------
	always @* begin
		case (trig_sel_q)
			`MCHC_SEL_CORR: trig = corr_pulse_q;
			`MCHC_SEL_T13P: trig = t13_period_i;
			`MCHC_SEL_T12O: trig = t12_one_down_i;
			`MCHC_SEL_T12C1: trig = t12_ch1_match_i;
			`MCHC_SEL_T12P: trig = t12_period_up_i;
			default: trig = 1'b0;
		endcase
	end
	// Hardware request only while the mode is enabled
	always @* begin
		case (sync_sel_q)
			`MCHC_SYN_DIRECT: sync = trig || pend_q;
			`MCHC_SYN_T13Z: sync = t13_zero_i;
			`MCHC_SYN_T12Z: sync = t12_zero_up_i;
			default: sync = 1'b0;
		endcase
	end
	// ----------------------------------------
	// Transfer decision
	// ----------------------------------------
	// Direct sync moves at once, so the flag never shows in that mode
	assign xfer = mc_en_q && sync && (pend_q || (trig && sync_sel_q == `MCHC_SYN_DIRECT));
	// ----------------------------------------
	// Gate pattern next value
	// ----------------------------------------
	// Idle wins over software, software over hardware
	always @* begin
		gate_d = gate_q;
		if (idle_q)
			gate_d = 6'h00;
		else if (sw_gate)
			gate_d = wdata_i[5:0];
		else if (xfer)
			gate_d = gate_sh_q;
	end
	// ----------------------------------------
	// Pending flag next value
	// ----------------------------------------
	// Clear on transfer or disable; a new trigger in a transfer cycle is lost
	always @* begin
		pend_d = pend_q;
		if (!mc_en_q)
			pend_d = 1'b0;
		else if (xfer)
			pend_d = 1'b0;
		else if (trig)
			pend_d = 1'b1;
	end
	// ----------------------------------------
	// Gate pattern and pending flag
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (rst_i)
			gate_q <= 6'h00;
		else
			gate_q <= gate_d;
	end
	always @(posedge mclk_i) begin
		if (rst_i)
			pend_q <= 1'b0;
		else
			pend_q <= pend_d;
	end
	// ----------------------------------------
	// Sensor pattern next values
	// ----------------------------------------
	// Software copy beats an edge reload in the same cycle
	always @* begin
		exp_d = exp_q;
		cur_d = cur_q;
		if (sw_sens) begin
			exp_d = wdata_i[2:0];
			cur_d = wdata_i[5:3];
		end else if (hall_edge) begin
			exp_d = exp_sh_q;
			cur_d = cur_sh_q;
		end
	end
	// ----------------------------------------
	// Event flag next values
	// ----------------------------------------
	// Set beats a clear in the same cycle
	always @* begin
		corr_d = corr_q;
		wrong_d = wrong_q;
		if (corr_hit)
			corr_d = 1'b1;
		else if (clr_corr)
			corr_d = 1'b0;
		if (wrong_hit)
			wrong_d = 1'b1;
		else if (clr_wrong)
			wrong_d = 1'b0;
	end
	// ----------------------------------------
	// Sensor patterns and event flags
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (rst_i) begin
			exp_q <= 3'h0;
			cur_q <= 3'h0;
		end else begin
			exp_q <= exp_d;
			cur_q <= cur_d;
		end
	end
	// Registered hit feeds the trigger select, cutting a long path
	always @(posedge mclk_i) begin
		if (rst_i)
			corr_pulse_q <= 1'b0;
		else
			corr_pulse_q <= corr_hit;
	end
	always @(posedge mclk_i) begin
		if (rst_i) begin
			corr_q <= 1'b0;
			wrong_q <= 1'b0;
		end else begin
			corr_q <= corr_d;
			wrong_q <= wrong_d;
		end
	end
	// ----------------------------------------
	// Event requests
	// ----------------------------------------
	// Flags stay sticky even while masked
	assign correct_irq_o = corr_q && cen_q;
	assign wrong_irq_o = wrong_q && wen_q;
	// ----------------------------------------
	// Output gating
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_out
			// Passive level wins while the mode is enabled and the pattern bit is low
			wire hold_passive;
			assign hold_passive = mc_en_q && !gate_q[g];
			always @(posedge mclk_i) begin
				if (rst_i)
					out_o[g] <= 1'b0;
				else if (hold_passive)
					out_o[g] <= passive_i[g];
				else
					out_o[g] <= pwm_i[g];
			end
		end
	endgenerate
	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Data stands one cycle only; idle cycles read zero
	always @* begin
		rdata_d = 8'h00;
		if (rd_i) begin
			case (addr_i)
				`MCHC_A_STAT_LO: rdata_d = {1'b0, pend_q, gate_q};
				`MCHC_A_STAT_HI: rdata_d = {2'b00, cur_q, exp_q};
				`MCHC_A_GATE_SH: rdata_d = {2'b00, gate_sh_q};
				`MCHC_A_SENS_SH: rdata_d = {2'b00, cur_sh_q, exp_sh_q};
				`MCHC_A_CTRL: rdata_d = {2'b00, sync_sel_q, 1'b0, trig_sel_q};
				`MCHC_A_MODE: rdata_d = {4'h0, wen_q, cen_q, idle_q, mc_en_q};
				`MCHC_A_EVENT: rdata_d = {5'h00, hall[0], wrong_q, corr_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end
	always @(posedge mclk_i) begin
		if (rst_i)
			rdata_o <= `MCHC_RST_BYTE;
		else
			rdata_o <= rdata_d;
	end
endmodule // mchc_top

// File: verif/mchc_stage_model.sv
`timescale 1ns/10ps
// ----
// Sensors and power stage
// ----
module mchc_stage_model #(
	parameter [5:0] PASSIVE = 6'h2a
) (
	// Wanted rotor position
	input wire [2:0] pos_i,
	// Sensor pins, stage passive levels
	output reg [2:0] sensor_o,
	output wire [5:0] passive_o
);
	// Sensors move off the clock grid
	initial sensor_o = 3'h0;
	always @(pos_i) sensor_o <= #7 pos_i;
	assign passive_o = PASSIVE;
endmodule // mchc_stage_model

// File: verif/mchc_top_assertions.sv
`timescale 1ns/10ps
// ----
// Port checks
// ----
module mchc_chk (
	// Clock, reset, bus
	input wire mclk_i,
	input wire rst_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	// Pins
	input wire [2:0] sensor_input_i,
	input wire [5:0] pwm_i,
	input wire [5:0] passive_i,
	input wire [5:0] out_o,
	input wire correct_irq_o,
	input wire wrong_irq_o
);
	reg [3:0] mode_q;
	reg [2:0] s_q;
	reg [3:0] qt_q;
	// Mode mirror; quiet count since a pin change
	always @(posedge mclk_i) begin
		s_q <= sensor_input_i;
		if (rst_i) begin
			mode_q <= 4'h0;
			qt_q <= 4'h0;
		end else begin
			if (wr_i && addr_i == 4'h5) mode_q <= wdata_i[3:0];
			qt_q <= (sensor_input_i != s_q) ? 4'h0 : qt_q + {3'h0, qt_q != 4'hf};
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	property p_rdz; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("rdata off slot");
	property p_lo; rd_i && addr_i == 4'h0 |=> !rdata_o[7]; endproperty
	a_lo: assert property (p_lo) else $error("lo reserved");
	property p_hi; rd_i && addr_i == 4'h1 |=> rdata_o[7:6] == 2'h0; endproperty
	a_hi: assert property (p_hi) else $error("hi reserved");
	property p_req; rd_i && addr_i == 4'h2 |=> !rdata_o[7]; endproperty
	a_req: assert property (p_req) else $error("request bit read");
	property p_byp; !mode_q[0] |=> out_o == $past(pwm_i); endproperty
	a_byp: assert property (p_byp) else $error("bypass");
	property p_idl; (mode_q[1:0] == 2'h3) [*2] |=> out_o == $past(passive_i); endproperty
	a_idl: assert property (p_idl) else $error("idle");
	property p_cen; correct_irq_o |-> mode_q[2]; endproperty
	a_cen: assert property (p_cen) else $error("correct mask");
	property p_wen; wrong_irq_o |-> mode_q[3]; endproperty
	a_wen: assert property (p_wen) else $error("wrong mask");
	// Flags rise only a few cycles after a pin change
	property p_cau; $rose(correct_irq_o | wrong_irq_o) && $past(mode_q[3:2]) == 2'h3
		|-> qt_q < 4'h9; endproperty
	a_cau: assert property (p_cau) else $error("event cause");
	cover property (correct_irq_o);
	cover property (wrong_irq_o);
	cover property (mode_q[1:0] == 2'h3);
endmodule // mchc_chk
bind mchc_top mchc_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.sensor_input_i(sensor_input_i), .pwm_i(pwm_i), .passive_i(passive_i),
	.out_o(out_o), .correct_irq_o(correct_irq_o), .wrong_irq_o(wrong_irq_o));

// File: verif/mchc_bench.sv
`timescale 1ns/10ps
module mchc_bench;
	reg mclk_i, rst_i, wr_i, rd_i;
	reg [3:0] addr_i;
	reg [7:0] wdata_i;
	reg [2:0] pos;
	reg [5:0] ev;
	wire [7:0] rdata_o;
	wire [2:0] sens;
	wire [5:0] pas, out_o;
	wire cirq, wirq;
	integer fail_count, cmp_count, k;
	mchc_stage_model stg (.pos_i(pos), .sensor_o(sens), .passive_o(pas));
	mchc_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sensor_input_i(sens),
		.pwm_i(6'h33), .passive_i(pas), .t13_period_i(ev[0]), .t13_zero_i(ev[1]),
		.t12_one_down_i(ev[2]), .t12_ch1_match_i(ev[3]), .t12_period_up_i(ev[4]),
		.t12_zero_up_i(ev[5]), .out_o(out_o), .correct_irq_o(cirq), .wrong_irq_o(wirq));
	// ----
	// Tasks
	// ----
	task ck(input [23:0] n, input [7:0] s, input [7:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (s !== e) begin
				fail_count = fail_count + 1;
				$display("ERROR %s expected %h seen %h", n, e, s);
			end
		end
	endtask
	task stop_test;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fail_count);
			if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	task wr(input [3:0] a, input [7:0] v);
		begin
			@(posedge mclk_i);
			addr_i <= a;
			wdata_i <= v;
			wr_i <= 1'b1;
			@(posedge mclk_i);
			wr_i <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			@(posedge mclk_i);
			addr_i <= a;
			rd_i <= 1'b1;
			@(posedge mclk_i);
			rd_i <= 1'b0;
			#1 ck("reg", rdata_o, e);
		end
	endtask
	task pulse(input [2:0] i);
		begin
			@(posedge mclk_i);
			ev <= 6'h01 << i;
			@(posedge mclk_i);
			ev <= 6'h00;
		end
	endtask
	// Bounded wait; a miss shows up as a mismatch
	task wt(input [7:0] e);
		begin
			repeat (20) if ((cirq | wirq) !== 1'b1) @(posedge mclk_i);
			#1 ck("irq", {6'h0, wirq, cirq}, e);
		end
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#3000000;
		fail_count = fail_count + 1;
		stop_test;
	end
	initial begin
		fail_count = 0;
		cmp_count = 0;
		{rst_i, wr_i, rd_i, addr_i, wdata_i, pos, ev} = 24'h800000;
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h7, 8'h00);
		ck("out", {2'h0, out_o}, 8'h33);
		$display("test reset done");
		wr(4'h5, 8'h01);
		wr(4'h2, 8'h95);
		rd(4'h0, 8'h15);
		rd(4'h2, 8'h15);
		ck("out", {2'h0, out_o}, 8'h3b);
		wr(4'h2, 8'h2a);
		rd(4'h0, 8'h15);
		for (k = 2; k < 6; k = k + 1) begin
			wr(4'h2, k[7:0]);
			wr(4'h4, k[7:0]);
			pulse(k == 2 ? 3'h0 : k[2:0] - 3'h1);
			rd(4'h0, k[7:0]);
		end
		wr(4'h2, 8'h3f);
		wr(4'h4, 8'h00);
		pulse(3'h4);
		rd(4'h0, 8'h05);
		wr(4'h4, 8'h12);
		pulse(3'h0);
		rd(4'h0, 8'h45);
		pulse(3'h5);
		rd(4'h0, 8'h45);
		pulse(3'h1);
		rd(4'h0, 8'h3f);
		wr(4'h4, 8'h25);
		wr(4'h2, 8'h09);
		pulse(3'h4);
		rd(4'h0, 8'h7f);
		wr(4'h5, 8'h00);
		rd(4'h0, 8'h3f);
		$display("test gate done");
		wr(4'h5, 8'h03);
		rd(4'h0, 8'h00);
		ck("out", {2'h0, out_o}, 8'h2a);
		wr(4'h5, 8'h0d);
		wr(4'h4, 8'h01);
		wr(4'h3, 8'h8b);
		rd(4'h1, 8'h0b);
		@(posedge mclk_i) pos <= 3'h3;
		wt(8'h01);
		rd(4'h6, 8'h05);
		rd(4'h0, 8'h09);
		wr(4'h6, 8'h03);
		@(posedge mclk_i) pos <= 3'h1;
		repeat (10) @(posedge mclk_i);
		rd(4'h6, 8'h04);
		wr(4'h3, 8'h31);
		@(posedge mclk_i) pos <= 3'h6;
		wt(8'h02);
		rd(4'h1, 8'h31);
		wr(4'h5, 8'h04);
		#1 ck("irq", {6'h0, wirq, cirq}, 8'h00);
		rd(4'h6, 8'h02);
		$display("test sensor done");
		stop_test;
	end
endmodule // mchc_bench
